/* File: rtl/pdaa_top.sv */
/*
 Paged data address unit with data-memory bus arbiter.
 Assumes requests come from logic on clk_i; EA carries the pointer value
 after modification, with overflow/underflow flagged by the generator.
*/
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
// What this block does
// - Read page above EA 14..0 when below 0x200
// - Write page above EA 14..0 on writes
// - Read page ten bits, write page nine
// - Read pages 0x200 up map program space
// - Writes never reach program space, no trap
// - Upper half with page zero traps
// - Both page registers reset to one
// - Writing zero leaves page register unchanged
// - EA bit 15 clear always page zero
// - Page adjust only pre/post indirect modes
// - Overflow increments page, sets bit 15
// - Underflow decrements page, sets bit 15
// - Offset/modulo/bitrev wrap, page untouched
// - Overflow at last pages, underflow at first pages, clears bit 15
// - Highest-priority requester granted, others held
// - Default order CPU, DMA, debugger
// - Priority 0x0020 puts DMA above CPU
// - Stack and active frame pointer unpaged
module pdaa_top
	import pdaa_pkg::*;
(
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     ce_i,
	input  wire logic [31:0]              wb_adr_i,
	input  wire logic [31:0]              wb_dat_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic                     wb_we_i,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	input  wire pdaa_req_type             agu_req_i,
	output pdaa_addr_type                 mem_addr_o,
	output logic                          addr_trap_o,
	input  wire logic [NUM_MASTERS-1:0]   bus_req_i,
	output logic      [NUM_MASTERS-1:0]   bus_gnt_o
);
	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic [READ_PAGE_W-1:0]  read_page_select_r;
	logic [WRITE_PAGE_W-1:0] write_page_select_r;
	logic [PRIO_W-1:0]       bus_master_priority_r;
	logic                    trap_seen_r;
	logic                    ack_r;
	logic [31:0]             rdata_r;
	logic                    bus_hit;
	logic                    bus_wr;
	logic [15:0]             wr_half;

	assign bus_hit = wb_cyc_i && wb_stb_i && !ack_r;
	assign bus_wr  = bus_hit && wb_we_i;
	assign wr_half = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};

	// One wait-free ack per request, dropped the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_r <= 1'b0;
		else if (ce_i)
			ack_r <= bus_hit;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_r <= 32'h0000_0000;
		else if (ce_i && bus_hit)
		begin
			unique case (wb_adr_i[3:0])
				ADDR_READ_PAGE:  rdata_r <= {22'h00_0000, read_page_select_r};
				ADDR_WRITE_PAGE: rdata_r <= {23'h00_0000, write_page_select_r};
				ADDR_PRIORITY:   rdata_r <= {16'h0000, bus_master_priority_r};
				ADDR_STATUS:     rdata_r <= {31'h0000_0000, trap_seen_r};
				default:         rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;

	// ----------------------------------------------------------------
	// Address formation
	// ----------------------------------------------------------------
	logic        upper;
	logic        unpaged;
	logic [9:0]  page;
	logic        page_adj;
	logic        trap;
	logic [9:0]  rd_next;
	logic [8:0]  wr_next;
	logic        ea_top_nxt;
	logic        rd_step;
	logic        wr_step;

	// Stack pointer never paged; frame pointer too while active
	assign unpaged = agu_req_i.stack_ptr || (agu_req_i.frame_ptr && agu_req_i.frame_active);
	assign upper   = agu_req_i.ea[EA_TOP] && !unpaged;
	assign page    = agu_req_i.write ? {1'b0, write_page_select_r} : read_page_select_r;
	assign page_adj = (agu_req_i.overflow || agu_req_i.underflow) && !unpaged;

	// Page zero through the upper half traps; nothing else traps, writes included
	assign trap = agu_req_i.valid && upper && (page == PAGE_ZERO);

	always_comb
	begin
		rd_next    = read_page_select_r;
		wr_next    = write_page_select_r;
		ea_top_nxt = agu_req_i.ea[EA_TOP];
		rd_step    = 1'b0;
		wr_step    = 1'b0;
		if (agu_req_i.valid && page_adj)
		begin
			unique case (agu_req_i.mode)
				MODE_PRE_POST:
				begin
					// Adjust only if the pointer started in a paged window
					if (page != PAGE_ZERO)
					begin
						ea_top_nxt = 1'b1;
						if (agu_req_i.write)
						begin
							if (agu_req_i.overflow && page == PAGE_EDS_LAST)
								ea_top_nxt = 1'b0;
							else if (agu_req_i.overflow)
							begin
								wr_next = write_page_select_r + 9'h001;
								wr_step = 1'b1;
							end
							else if (page == PAGE_FIRST)
								ea_top_nxt = 1'b0;
							else
							begin
								wr_next = write_page_select_r - 9'h001;
								wr_step = 1'b1;
							end
						end
						else if (agu_req_i.overflow)
						begin
							if (page == PAGE_EDS_LAST || page == PAGE_PS_LAST)
								ea_top_nxt = 1'b0;
							else
							begin
								// 0x2FF steps to 0x300 by plain increment
								rd_next = read_page_select_r + 10'h001;
								rd_step = 1'b1;
							end
						end
						else
						begin
							if (page == PAGE_FIRST || page == PAGE_PS_FIRST)
								ea_top_nxt = 1'b0;
							else
							begin
								rd_next = read_page_select_r - 10'h001;
								rd_step = 1'b1;
							end
						end
					end
				end
				MODE_REG_OFFSET, MODE_MOD_BITREV:
					ea_top_nxt = 1'b1;
				MODE_DIRECT:
					ea_top_nxt = agu_req_i.ea[EA_TOP];
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Page registers
	// ----------------------------------------------------------------
	// Software write wins over hardware stepping in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			read_page_select_r <= PAGE_RESET;
		else if (ce_i)
		begin
			if (bus_wr && wb_adr_i[3:0] == ADDR_READ_PAGE && |wb_sel_i[1:0])
			begin
				if (wr_half[READ_PAGE_W-1:0] != PAGE_ZERO)
					read_page_select_r <= wr_half[READ_PAGE_W-1:0];
			end
			else if (rd_step && !trap)
				read_page_select_r <= rd_next;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			write_page_select_r <= PAGE_RESET[WRITE_PAGE_W-1:0];
		else if (ce_i)
		begin
			if (bus_wr && wb_adr_i[3:0] == ADDR_WRITE_PAGE && |wb_sel_i[1:0])
			begin
				if (wr_half[WRITE_PAGE_W-1:0] != PAGE_ZERO[WRITE_PAGE_W-1:0])
					write_page_select_r <= wr_half[WRITE_PAGE_W-1:0];
			end
			else if (wr_step && !trap)
				write_page_select_r <= wr_next;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bus_master_priority_r <= PRIO_DEFAULT;
		else if (ce_i && bus_wr && wb_adr_i[3:0] == ADDR_PRIORITY && |wb_sel_i[1:0])
			bus_master_priority_r <= wr_half;
	end

	// Sticky trap flag; set beats a clear in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			trap_seen_r <= 1'b0;
		else if (ce_i)
		begin
			if (trap)
				trap_seen_r <= 1'b1;
			else if (bus_wr && wb_adr_i[3:0] == ADDR_STATUS && wb_sel_i[0] && wb_dat_i[0])
				trap_seen_r <= 1'b0;
		end
	end

	// Registered address output
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mem_addr_o  <= '0;
			addr_trap_o <= 1'b0;
		end
		else if (ce_i)
		begin
			addr_trap_o           <= trap;
			mem_addr_o.valid      <= agu_req_i.valid && !trap;
			mem_addr_o.write      <= agu_req_i.write;
			mem_addr_o.trap       <= trap;
			mem_addr_o.ea_top     <= ea_top_nxt;
			mem_addr_o.prog_space <= upper && !agu_req_i.write && read_page_select_r[PS_BIT];
			if (!upper)
				mem_addr_o.addr <= {8'h00, agu_req_i.ea};
			else if (agu_req_i.write)
				mem_addr_o.addr <= {write_page_select_r, agu_req_i.ea[14:0]};
			else
				mem_addr_o.addr <= {read_page_select_r[8:0], agu_req_i.ea[14:0]};
		end
	end

	// ----------------------------------------------------------------
	// Bus arbiter
	// ----------------------------------------------------------------
	logic dma_first;

	// Reserved priority values fall back to default order
	assign dma_first = (bus_master_priority_r == PRIO_DMA_FIRST);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bus_gnt_o <= '0;
		else if (ce_i)
		begin
			bus_gnt_o <= '0;
			if (dma_first && bus_req_i[MST_DMA])
				bus_gnt_o[MST_DMA] <= 1'b1;
			else if (bus_req_i[MST_CPU])
				bus_gnt_o[MST_CPU] <= 1'b1;
			else if (bus_req_i[MST_DMA])
				bus_gnt_o[MST_DMA] <= 1'b1;
			else if (bus_req_i[MST_DBG])
				bus_gnt_o[MST_DBG] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic pre_post_rd;

	// Qualified read step with no bus write racing it
	assign pre_post_rd = ce_i && agu_req_i.valid && page_adj && agu_req_i.mode == MODE_PRE_POST
		&& !agu_req_i.write && !bus_wr;

	AST_RESET_PAGE: assert property (@(posedge clk_i) $fell(rst_i) |-> read_page_select_r == PAGE_RESET
		&& write_page_select_r == PAGE_RESET[WRITE_PAGE_W-1:0])
		else $error("page register not one after reset");
	AST_ZERO_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && bus_wr && wb_adr_i[3:0] == ADDR_READ_PAGE && wb_sel_i[1:0] == 2'h3 && wb_dat_i[9:0] == 10'h000)
		|=> $stable(read_page_select_r))
		else $error("zero write changed read page");
	AST_PAGE_NONZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		read_page_select_r != PAGE_ZERO && write_page_select_r != PAGE_ZERO[WRITE_PAGE_W-1:0])
		else $error("page register reached zero");
	AST_LOW_HALF: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !agu_req_i.ea[15]) |=> mem_addr_o.addr[23:16] == 8'h00 && !addr_trap_o)
		else $error("low half address paged");
	AST_UNPAGED: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && unpaged) |=> mem_addr_o.addr[23:16] == 8'h00)
		else $error("stack or frame pointer paged");

	// Unreachable while zero writes are ignored; kept against later changes
	AST_TRAP_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && agu_req_i.valid && upper && page == PAGE_ZERO) |=> addr_trap_o && !mem_addr_o.valid)
		else $error("page zero access not trapped");
	AST_TRAP_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && trap) |=> trap_seen_r)
		else $error("trap not recorded");
	AST_RD_VALID: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && agu_req_i.valid && !trap) |=> mem_addr_o.valid)
		else $error("untrapped request not passed on");
	AST_READ_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && upper && !agu_req_i.write) |=> mem_addr_o.addr[23:15] == $past(read_page_select_r[8:0]))
		else $error("read address page bits wrong");
	AST_WRITE_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && upper && agu_req_i.write) |=> mem_addr_o.addr[23:15] == $past(write_page_select_r))
		else $error("write address page bits wrong");
	AST_PROG_SPACE: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && upper && !agu_req_i.write && read_page_select_r[PS_BIT]) |=> mem_addr_o.prog_space)
		else $error("high read page not mapped to program space");
	AST_NO_PS_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && agu_req_i.write) |=> !mem_addr_o.prog_space)
		else $error("write reached program space");

	AST_OVF_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && rd_step && agu_req_i.overflow && !trap && !bus_wr)
		|=> read_page_select_r == $past(read_page_select_r) + 10'h001)
		else $error("read page not incremented");
	AST_UDF_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && rd_step && agu_req_i.underflow && !agu_req_i.overflow && !trap && !bus_wr)
		|=> read_page_select_r == $past(read_page_select_r) - 10'h001)
		else $error("read page not decremented");
	AST_WRAP_MODE: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && agu_req_i.valid && page_adj && agu_req_i.mode == MODE_REG_OFFSET && !bus_wr)
		|=> $stable(read_page_select_r) && $stable(write_page_select_r) && mem_addr_o.ea_top)
		else $error("offset mode changed page");
	AST_EDGE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		(pre_post_rd && agu_req_i.overflow
		&& (read_page_select_r == PAGE_EDS_LAST || read_page_select_r == PAGE_PS_LAST))
		|=> $stable(read_page_select_r) && !mem_addr_o.ea_top)
		else $error("last page overflow not held");
	AST_CROSS_UP: assert property (@(posedge clk_i) disable iff (rst_i)
		(pre_post_rd && agu_req_i.overflow && read_page_select_r == PAGE_PS_LSW_LAST)
		|=> read_page_select_r == PAGE_PS_MSB_1ST && mem_addr_o.ea_top)
		else $error("window crossing upward wrong");
	AST_CROSS_DOWN: assert property (@(posedge clk_i) disable iff (rst_i)
		(pre_post_rd && agu_req_i.underflow && !agu_req_i.overflow && read_page_select_r == PAGE_PS_MSB_1ST)
		|=> read_page_select_r == PAGE_PS_LSW_LAST && mem_addr_o.ea_top)
		else $error("window crossing downward wrong");
	AST_UDF_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		(pre_post_rd && agu_req_i.underflow && !agu_req_i.overflow
		&& (read_page_select_r == PAGE_FIRST || read_page_select_r == PAGE_PS_FIRST))
		|=> $stable(read_page_select_r) && !mem_addr_o.ea_top)
		else $error("first page underflow not held");

	AST_GNT_ONEHOT: assert property (@(posedge clk_i) disable iff (rst_i) $onehot0(bus_gnt_o))
		else $error("more than one grant");
	AST_ANY_GNT: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && |bus_req_i) |=> |bus_gnt_o)
		else $error("pending request left without grant");
	AST_DMA_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && dma_first && bus_req_i[MST_DMA]) |=> bus_gnt_o[MST_DMA])
		else $error("raised dma not granted");
	AST_CPU_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !dma_first && bus_req_i[MST_CPU]) |=> bus_gnt_o[MST_CPU])
		else $error("cpu not granted first");
	AST_DBG_LAST: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && bus_req_i[MST_DBG] && (bus_req_i[MST_CPU] || bus_req_i[MST_DMA])) |=> !bus_gnt_o[MST_DBG])
		else $error("debugger granted over another master");

	// Ack may stand longer only while frozen
	AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && wb_ack_o) |=> !wb_ack_o)
		else $error("ack held past one cycle");
	AST_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
		!ce_i |=> $stable(read_page_select_r) && $stable(write_page_select_r) && $stable(bus_gnt_o)
		&& $stable(mem_addr_o))
		else $error("state moved while clock enable low");
endmodule // pdaa_top

/* File: common/pdaa_pkg.sv */
/*
 Package for the paged data address unit and bus arbiter: register offsets,
 page constants, arbiter slots and the carrier structs.
 Assumes a 32-bit Wishbone classic register bus with byte offsets.
*/
package pdaa_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0]  ADDR_READ_PAGE   = 4'h0;
	localparam logic [3:0]  ADDR_WRITE_PAGE  = 4'h4;
	localparam logic [3:0]  ADDR_PRIORITY    = 4'h8;
	localparam logic [3:0]  ADDR_STATUS      = 4'hC;
	localparam int          READ_PAGE_W      = 10;
	localparam int          WRITE_PAGE_W     = 9;
	localparam int          PRIO_W           = 16;
	localparam logic [9:0]  PAGE_RESET       = 10'h001;
	// ----------------------------------------------------------------
	// Page boundaries
	// ----------------------------------------------------------------
	localparam logic [9:0]  PAGE_ZERO        = 10'h000;
	localparam logic [9:0]  PAGE_EDS_LAST    = 10'h1FF;
	localparam logic [9:0]  PAGE_PS_FIRST    = 10'h200;
	localparam logic [9:0]  PAGE_PS_LSW_LAST = 10'h2FF;
	localparam logic [9:0]  PAGE_PS_MSB_1ST  = 10'h300;
	localparam logic [9:0]  PAGE_PS_LAST     = 10'h3FF;
	localparam logic [9:0]  PAGE_FIRST       = 10'h001;
	localparam int          PS_BIT           = 9;
	localparam int          EA_TOP           = 15;
	// ----------------------------------------------------------------
	// Arbiter
	// ----------------------------------------------------------------
	localparam logic [15:0] PRIO_DEFAULT     = 16'h0000;
	localparam logic [15:0] PRIO_DMA_FIRST   = 16'h0020;
	localparam int          NUM_MASTERS      = 3;
	localparam int          MST_CPU          = 0;
	localparam int          MST_DMA          = 1;
	localparam int          MST_DBG          = 2;

	typedef enum logic [1:0] {
		MODE_DIRECT,
		MODE_PRE_POST,
		MODE_REG_OFFSET,
		MODE_MOD_BITREV
	} pdaa_mode_type;

	// Access request from an address generator
	typedef struct packed {
		logic          valid;
		logic          write;
		logic [15:0]   ea;
		logic          stack_ptr;
		logic          frame_ptr;
		logic          frame_active;
		logic          overflow;
		logic          underflow;
		pdaa_mode_type mode;
	} pdaa_req_type;

	typedef struct packed {
		logic          valid;
		logic          write;
		logic          prog_space;
		logic [23:0]   addr;
		logic          ea_top;
		logic          trap;
	} pdaa_addr_type;
endpackage

/* File: test/pdaa_masters.sv */
/*
 Model of the bus masters: CPU, DMA and debugger.
 Assumes one-hot grants one cycle after requests.
*/
`timescale 1ns/10ps
module pdaa_masters
	import pdaa_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic [NUM_MASTERS-1:0] want_i,
	input  wire logic [NUM_MASTERS-1:0] bus_gnt_i,
	output logic      [NUM_MASTERS-1:0] bus_req_o
);
	// ----------------------------------------
	// Request held until served
	// ----------------------------------------
	// Real masters stall, so no request is withdrawn early
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bus_req_o <= '0;
		else
			bus_req_o <= (bus_req_o & ~bus_gnt_i) | want_i;
	end
endmodule // pdaa_masters

/* File: test/tb_pdaa_top.sv */
/*
 Self-checking bench for the paging unit and arbiter.
 Assumes one-cycle ack and registered address and grant outputs.
*/
`timescale 1ns/10ps
module tb_pdaa_top
	import pdaa_pkg::*;
;
	logic          clk_i, rst_i, ce_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, addr_trap_o;
	logic [31:0]   wb_adr_i, wb_dat_i, wb_dat_o, rd;
	pdaa_req_type  agu_req_i;
	pdaa_addr_type mem_addr_o, got;
	logic [2:0]    bus_req, bus_gnt_o, want;
	int            fail_count, n_compared, cycles;

	pdaa_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(4'h3), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .agu_req_i(agu_req_i),
		.mem_addr_o(mem_addr_o), .addr_trap_o(addr_trap_o), .bus_req_i(bus_req),
		.bus_gnt_o(bus_gnt_o));
	pdaa_masters masters (.clk_i(clk_i), .rst_i(rst_i), .want_i(want),
		.bus_gnt_i(bus_gnt_o), .bus_req_o(bus_req));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Held until the edge that sees ack
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {28'h0, a};
		wb_dat_i <= d;
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task agu(input pdaa_req_type r);
		@(posedge clk_i);
		agu_req_i <= r;
		@(posedge clk_i);
		agu_req_i <= '0;
		@(negedge clk_i);
		got = mem_addr_o;
	endtask

	task t_rst;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		wb(1'b0, ADDR_READ_PAGE, 32'h0);
		chk("read_page", 32'h1, rd);
		wb(1'b0, ADDR_WRITE_PAGE, 32'h0);
		chk("write_page", 32'h1, rd);
		wb(1'b0, ADDR_PRIORITY, 32'h0);
		chk("priority", 32'h0, rd);
		wb(1'b1, ADDR_READ_PAGE, 32'h0);
		wb(1'b0, ADDR_READ_PAGE, 32'h0);
		chk("read_page", 32'h1, rd);
		wb(1'b1, ADDR_WRITE_PAGE, 32'h0);
		wb(1'b0, ADDR_WRITE_PAGE, 32'h0);
		chk("write_page", 32'h1, rd);
		wb(1'b1, ADDR_READ_PAGE, 32'h7FF);
		wb(1'b0, ADDR_READ_PAGE, 32'h0);
		chk("read_page", 32'h3FF, rd);
		wb(1'b1, ADDR_WRITE_PAGE, 32'h3FF);
		wb(1'b0, ADDR_WRITE_PAGE, 32'h0);
		chk("write_page", 32'h1FF, rd);
		wb(1'b0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, rd);
		wb(1'b0, ADDR_STATUS, 32'h0);
		chk("status", 32'h0, rd);
		t_rst();
		wb(1'b0, ADDR_READ_PAGE, 32'h0);
		chk("read_page", 32'h1, rd);
		$display("register test done");
	endtask

	task t_map(input logic [9:0] p, input logic w, s, input logic [15:0] ea,
		input logic [23:0] e, input logic ps);
		pdaa_req_type r;
		wb(1'b1, w ? ADDR_WRITE_PAGE : ADDR_READ_PAGE, {22'h0, p});
		r = '0;
		r.valid = 1'b1;
		r.write = w;
		r.stack_ptr = s;
		r.ea = ea;
		agu(r);
		chk("prog_space", {31'h0, ps}, {31'h0, got.prog_space});
		chk("flags", {29'h0, 1'b1, w, 1'b0}, {29'h0, got.valid, got.write, addr_trap_o});
		if (!ps)
			chk("addr", {8'h0, e}, {8'h0, got.addr});
		$display("map test done");
	endtask

	task t_step(input logic [9:0] p, input logic w, input pdaa_mode_type m,
		input logic o, u, input logic [9:0] ep, input logic et);
		pdaa_req_type r;
		wb(1'b1, w ? ADDR_WRITE_PAGE : ADDR_READ_PAGE, {22'h0, p});
		r = '0;
		r.valid = 1'b1;
		r.write = w;
		r.ea = 16'h7FFE;
		r.mode = m;
		r.overflow = o;
		r.underflow = u;
		agu(r);
		chk("ea_top", {31'h0, et}, {31'h0, got.ea_top});
		wb(1'b0, w ? ADDR_WRITE_PAGE : ADDR_READ_PAGE, 32'h0);
		chk("page", {22'h0, ep}, rd);
		$display("step test done");
	endtask

	// Clock enable low must freeze paging and the address output
	task t_hold;
		pdaa_req_type r;
		wb(1'b1, ADDR_READ_PAGE, 32'h5);
		r = '0;
		r.valid = 1'b1;
		r.ea = 16'h8000;
		r.mode = MODE_PRE_POST;
		r.overflow = 1'b1;
		@(posedge clk_i);
		ce_i <= 1'b0;
		agu(r);
		chk("frozen_valid", 32'h0, {31'h0, got.valid});
		@(posedge clk_i);
		ce_i <= 1'b1;
		wb(1'b0, ADDR_READ_PAGE, 32'h0);
		chk("frozen_page", 32'h5, rd);
		$display("hold test done");
	endtask

	// Records the first grant of each master
	task t_arb(input logic [15:0] p, input logic [5:0] e);
		logic [5:0] seq;
		logic [2:0] seen;
		seq = '0;
		seen = '0;
		wb(1'b1, ADDR_PRIORITY, {16'h0, p});
		@(posedge clk_i);
		want <= 3'b111;
		@(posedge clk_i);
		want <= 3'b000;
		repeat (12)
		begin
			@(negedge clk_i);
			for (int k = 0; k < 3; k++)
				if (bus_gnt_o[k] === 1'b1 && !seen[k])
				begin
					seq = {seq[3:0], 2'(k)};
					seen[k] = 1'b1;
				end
		end
		chk("grant_order", {26'h0, e}, {26'h0, seq});
		$display("arbiter test done");
	endtask

	// ----------------------------------------
	// Clock, timeout and main sequence
	// ----------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			final_report();
		end
	end

	initial
	begin
		{rst_i, wb_we_i, wb_cyc_i, wb_stb_i} = 4'h8;
		ce_i = 1'b1;
		{wb_adr_i, wb_dat_i} = '0;
		agu_req_i = '0;
		want = '0;
		{fail_count, n_compared, cycles} = '0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_map(10'h005, 1'b0, 1'b0, 16'h8123, 24'h028123, 1'b0);
		t_map(10'h002, 1'b1, 1'b0, 16'h8000, 24'h010000, 1'b0);
		t_map(10'h005, 1'b0, 1'b0, 16'h1234, 24'h001234, 1'b0);
		t_map(10'h005, 1'b1, 1'b0, 16'h7FFE, 24'h007FFE, 1'b0);
		t_map(10'h200, 1'b0, 1'b0, 16'h8000, 24'h000000, 1'b1);
		t_map(10'h005, 1'b0, 1'b1, 16'h9000, 24'h009000, 1'b0);
		t_hold();
		t_step(10'h005, 1'b0, MODE_PRE_POST, 1'b1, 1'b0, 10'h006, 1'b1);
		t_step(10'h006, 1'b1, MODE_PRE_POST, 1'b1, 1'b0, 10'h007, 1'b1);
		t_step(10'h005, 1'b0, MODE_PRE_POST, 1'b0, 1'b1, 10'h004, 1'b1);
		t_step(10'h005, 1'b0, MODE_REG_OFFSET, 1'b1, 1'b0, 10'h005, 1'b1);
		t_step(10'h005, 1'b1, MODE_MOD_BITREV, 1'b0, 1'b1, 10'h005, 1'b1);
		t_step(10'h1FF, 1'b0, MODE_PRE_POST, 1'b1, 1'b0, 10'h1FF, 1'b0);
		t_step(10'h3FF, 1'b0, MODE_PRE_POST, 1'b1, 1'b0, 10'h3FF, 1'b0);
		t_step(10'h1FF, 1'b1, MODE_PRE_POST, 1'b1, 1'b0, 10'h1FF, 1'b0);
		t_step(10'h2FF, 1'b0, MODE_PRE_POST, 1'b1, 1'b0, 10'h300, 1'b1);
		t_step(10'h300, 1'b0, MODE_PRE_POST, 1'b0, 1'b1, 10'h2FF, 1'b1);
		t_step(10'h001, 1'b0, MODE_PRE_POST, 1'b0, 1'b1, 10'h001, 1'b0);
		t_step(10'h200, 1'b0, MODE_PRE_POST, 1'b0, 1'b1, 10'h200, 1'b0);
		t_step(10'h001, 1'b1, MODE_PRE_POST, 1'b0, 1'b1, 10'h001, 1'b0);
		t_step(10'h005, 1'b0, MODE_DIRECT, 1'b1, 1'b0, 10'h005, 1'b0);
		t_arb(PRIO_DEFAULT, 6'h06);
		t_arb(PRIO_DMA_FIRST, 6'h12);
		final_report();
	end
endmodule // tb_pdaa_top
